/* common/acs_pkg.sv */
// Constants and types shared by the converter sequencer.
package acs_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
  localparam logic [4:0] OFF_CTRL_TWO = 5'h04;
  localparam logic [4:0] OFF_AUX_TWO  = 5'h08;
  localparam logic [4:0] OFF_IRQ_CTRL = 5'h0C;
  localparam logic [4:0] OFF_RES_HIGH = 5'h10;
  localparam logic [4:0] OFF_RES_LOW  = 5'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_ON = 0;
  localparam int BIT_GO       = 1;
  localparam int BIT_FORMAT   = 7;
  localparam int BIT_CLK_HI   = 6;
  localparam int BIT_CLK_LO   = 4;
  localparam int BIT_REF_HI   = 1;
  localparam int BIT_DONE     = 0;
  localparam int BIT_IRQ_EN   = 1;
  localparam int BIT_GATE     = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [2:0] RST_TRIG   = 3'h0;

  // ----------------------------------------------------------------
  // Conversion clock codes and divide ratios
  // ----------------------------------------------------------------
  localparam logic [2:0] CLK_DIV2  = 3'h0;
  localparam logic [2:0] CLK_DIV8  = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_DIV4  = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [6:0] DIV_2  = 7'h02;
  localparam logic [6:0] DIV_4  = 7'h04;
  localparam logic [6:0] DIV_8  = 7'h08;
  localparam logic [6:0] DIV_16 = 7'h10;
  localparam logic [6:0] DIV_32 = 7'h20;
  localparam logic [6:0] DIV_64 = 7'h40;
  // Trial code flop plus two comparator sync flops: shortest bit time.
  localparam logic [6:0] LOOP_CYCLES = 7'h04;

  // ----------------------------------------------------------------
  // Timing: one instruction is four oscillator periods
  // ----------------------------------------------------------------
  localparam int         OSC_PER_INSTR = 4;
  localparam logic [2:0] INSTR_CYCLES  = 3'(OSC_PER_INSTR);

  // Trigger source codes; 0 means no hardware trigger.
  localparam logic [2:0] TRIG_NONE = 3'h0;

  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_DELAY = 2'b01,
    ACS_CONV  = 2'b10
  } acs_state_t;

endpackage

/* core/acs_sequencer.sv */
// Converter sequencer with an Avalon-MM register slave.
`timescale 1ns/1ps
// Behaviour
// RQ1: Converter works only while the power-on bit is 1.
// RQ2: Writing 1 to the go bit starts a conversion.
// RQ3: Software should power on first and start in a later write.
// RQ4: At completion clear go, set done flag, load result bytes.
// RQ5: Clearing go mid-conversion stops and stores the partial result.
// RQ6: Unresolved bits of an aborted result copy the last resolved bit.
// RQ7: Reset restores registers, powers off and aborts any conversion.
// RQ8: With the RC clock, start waits one extra instruction cycle.
// RQ9: RC conversion finishing in sleep with interrupt enabled wakes core.
// RQ10: Finishing in sleep with interrupt off turns module off, bit stays.
// RQ11: Sleep with a non-RC clock aborts and turns off, bit stays.
// RQ12: Selected hardware trigger sets the go bit.
// RQ13: Software using triggers must meet acquisition timing itself.
// RQ14: Format bit 7 set gives right-justified, clear left-justified.
// RQ15: Clock select 000 divides by 2, 001 by 8.
// RQ16: Bits 3 and 2 of control two read as 0.
// RQ17: Interrupt enable gates the done flag onto the interrupt.
// RQ18: Peripheral gate must also be 1 for the interrupt to leave.
// RQ19: Go bit reads 1 throughout an active conversion.
// RQ20: A trigger while powered off starts nothing.
module acs_sequencer
  import acs_pkg::*;
#(
  parameter int RES_W = 10
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  input  wire logic        i_cmp,
  input  wire logic        i_rc_clk,
  input  wire logic        i_sleep,
  input  wire logic [4:0]  i_trig,
  output logic [RES_W-1:0] o_dac_code,
  output logic             o_sample,
  output logic             o_irq,
  output logic             o_wake
);

  // Widths that the justify shifters and the bit index cannot serve.
  if (RES_W < 9 || RES_W > 16) begin : g_width_check
    $error("RES_W must lie between 9 and 16");
  end

  // ----------------------------------------------------------------
  // Reset release and input synchronisers
  // ----------------------------------------------------------------
  logic       rst_meta;
  logic       rst_n;
  logic [1:0] cmp_sync;
  logic [1:0] rc_sync;
  logic       rc_last;

  // Reset asserts at once but leaves on two clean edges.
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Comparator and RC clock come from the analog side.
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_sync <= 2'b00;
      rc_sync  <= 2'b00;
      rc_last  <= 1'b0;
    end else begin
      cmp_sync <= {cmp_sync[0], i_cmp};
      rc_sync  <= {rc_sync[0], i_rc_clk};
      rc_last  <= rc_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic             power_on;
  logic             format_right;
  logic [2:0]       clk_sel;
  logic [1:0]       ref_sel;
  logic [2:0]       trig_sel;
  logic             done_flag;
  logic             irq_en;
  logic             gate;
  logic [7:0]       res_high;
  logic [7:0]       res_low;
  logic             sleep_off;
  acs_state_t       state;
  logic [3:0]       bit_idx;
  logic [RES_W-1:0] sar;
  logic [6:0]       div_cnt;
  logic [2:0]       dly_cnt;
  logic             ack;

  logic       acc_wr;
  logic       wr_ctrl1;
  logic       powered;
  logic       use_rc;
  logic [6:0] div_ratio;
  logic [6:0] bit_len;
  logic       settled;
  logic       conv_tick;
  logic       trig_hit;
  logic       start_req;
  logic       abort_req;
  logic       sleep_abort;
  logic       finish;
  logic       partial;
  logic [RES_W-1:0] final_res;
  logic [RES_W-1:0] store_val;

  // A write lands on the edge where waitrequest is low.
  assign acc_wr   = i_avs_write & ack & i_avs_byteenable[0];
  assign wr_ctrl1 = acc_wr & (i_avs_address == OFF_CTRL_ONE);
  // RQ1 power-on gating
  assign powered  = power_on & ~sleep_off;
  assign use_rc   = (clk_sel[1:0] == 2'b11);

  // RQ15 clock divide decode
  always_comb begin
    unique case (clk_sel)
      CLK_DIV2:  div_ratio = DIV_2;
      CLK_DIV8:  div_ratio = DIV_8;
      CLK_DIV32: div_ratio = DIV_32;
      CLK_DIV4:  div_ratio = DIV_4;
      CLK_DIV16: div_ratio = DIV_16;
      CLK_DIV64: div_ratio = DIV_64;
      default:   div_ratio = DIV_2;
    endcase
  end

  // The comparator answer for a new trial code needs four cycles to come
  // back, so the fastest divide spends two of its periods on each bit.
  assign bit_len   = (div_ratio < LOOP_CYCLES) ? LOOP_CYCLES : div_ratio;
  // An RC edge that comes before the comparator has settled is skipped.
  assign settled   = (div_cnt >= LOOP_CYCLES - 7'd1);
  // Conversion clock: a rising RC edge or the end of a bit period.
  assign conv_tick = use_rc ? (rc_sync[1] & ~rc_last & settled)
                            : (div_cnt == bit_len - 7'd1);

  // RQ12 trigger select; RQ20 powered only
  assign trig_hit = (trig_sel != TRIG_NONE) && (trig_sel <= 3'd5) &&
                    i_trig[trig_sel - 3'd1] && powered;
  // RQ2 software start
  assign start_req = (state == ACS_IDLE) && powered &&
                     ((wr_ctrl1 && i_avs_writedata[BIT_GO] && power_on) ||
                      trig_hit);
  // RQ5 software abort
  assign abort_req = (state != ACS_IDLE) && wr_ctrl1 &&
                     !i_avs_writedata[BIT_GO];
  // RQ11 sleep without the RC clock
  assign sleep_abort = (state != ACS_IDLE) &&
                       ((i_sleep && !use_rc) || !powered);
  assign finish  = (state == ACS_CONV) && conv_tick && (bit_idx == 4'd0) &&
                   !abort_req && !sleep_abort;
  assign partial = abort_req && !sleep_abort;

  // RQ6 fill unresolved bits with the last resolved one
  always_comb begin
    final_res    = sar;
    final_res[0] = cmp_sync[1];
    store_val    = sar;
    for (int k = 0; k < RES_W; k++) begin
      if (k <= int'(bit_idx)) begin
        store_val[k] = (int'(bit_idx) == RES_W - 1) ? 1'b0
                       : sar[bit_idx + 4'd1];
      end
    end
    if (state == ACS_DELAY) begin
      store_val = '0;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // RQ4 RQ8 RQ19 conversion steps
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ACS_IDLE;
      bit_idx <= 4'd0;
      sar     <= '0;
      dly_cnt <= 3'd0;
    end else begin
      unique case (state)
        ACS_IDLE: begin
          if (start_req) begin
            sar     <= '0;
            bit_idx <= 4'(RES_W - 1);
            dly_cnt <= INSTR_CYCLES;
            state   <= use_rc ? ACS_DELAY : ACS_CONV;
          end
        end
        ACS_DELAY: begin
          if (abort_req || sleep_abort) begin
            state <= ACS_IDLE;
          end else if (dly_cnt == 3'd1) begin
            state <= ACS_CONV;
          end else begin
            dly_cnt <= dly_cnt - 3'd1;
          end
        end
        ACS_CONV: begin
          if (abort_req || sleep_abort) begin
            state <= ACS_IDLE;
          end else if (conv_tick) begin
            // Keep the trial bit when the input is at or above it.
            sar[bit_idx] <= cmp_sync[1];
            if (bit_idx == 4'd0) begin
              state <= ACS_IDLE;
            end else begin
              bit_idx <= bit_idx - 4'd1;
            end
          end
        end
        default: state <= ACS_IDLE;
      endcase
    end
  end

  // Divider restarts with each conversion so every bit gets a full period.
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 7'd0;
    end else if (state != ACS_CONV || conv_tick) begin
      div_cnt <= 7'd0;
    end else begin
      div_cnt <= div_cnt + 7'd1;
    end
  end

  // Trial code for the DAC: resolved bits plus the bit under test.
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_dac_code <= '0;
      o_sample   <= 1'b0;
    end else begin
      o_dac_code <= (state == ACS_CONV)
                    ? (sar | (RES_W'(1) << bit_idx)) : '0;
      o_sample   <= (state == ACS_DELAY);
    end
  end

  // RQ10 RQ11 module off in sleep, power-on bit untouched
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sleep_off <= 1'b0;
    end else if (!i_sleep) begin
      sleep_off <= 1'b0;
    end else if ((finish && !irq_en) || (state != ACS_IDLE && !use_rc)) begin
      sleep_off <= 1'b1;
    end
  end

  // RQ4 RQ5 RQ14 result store, justified by the format bit
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      res_high <= RST_BYTE;
      res_low  <= RST_BYTE;
    end else if (finish || partial) begin
      if (format_right) begin
        res_high <= 8'((finish ? final_res : store_val) >> 8);
        res_low  <= (finish ? final_res[7:0] : store_val[7:0]);
      end else begin
        res_high <= 8'((finish ? final_res : store_val) >> (RES_W - 8));
        res_low  <= 8'((finish ? final_res : store_val) << (16 - RES_W));
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // RQ7 reset values for all control bits
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_on     <= 1'b0;
      format_right <= 1'b0;
      clk_sel      <= 3'h0;
      ref_sel      <= 2'h0;
      trig_sel     <= RST_TRIG;
      irq_en       <= 1'b0;
      gate         <= 1'b0;
    end else if (acc_wr) begin
      unique case (i_avs_address)
        OFF_CTRL_ONE: power_on <= i_avs_writedata[BIT_POWER_ON];
        OFF_CTRL_TWO: begin
          format_right <= i_avs_writedata[BIT_FORMAT];
          clk_sel      <= i_avs_writedata[BIT_CLK_HI:BIT_CLK_LO];
          ref_sel      <= i_avs_writedata[BIT_REF_HI:0];
        end
        OFF_AUX_TWO: trig_sel <= i_avs_writedata[2:0];
        OFF_IRQ_CTRL: begin
          irq_en <= i_avs_writedata[BIT_IRQ_EN];
          gate   <= i_avs_writedata[BIT_GATE];
        end
        default: ;
      endcase
    end
  end

  // RQ4 done flag: completion wins over a software clear.
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (finish) begin
      done_flag <= 1'b1;
    end else if (acc_wr && i_avs_address == OFF_IRQ_CTRL) begin
      done_flag <= i_avs_writedata[BIT_DONE];
    end
  end

  // RQ17 RQ18 interrupt gating; RQ9 wake pulse
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq  <= 1'b0;
      o_wake <= 1'b0;
    end else begin
      o_irq  <= done_flag & irq_en & gate;
      o_wake <= finish & i_sleep & irq_en & use_rc;
    end
  end

  // ----------------------------------------------------------------
  // Avalon read path: one wait cycle, data registered
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack            <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      ack            <= (i_avs_read | i_avs_write) & ~ack;
      o_avs_readdata <= 32'h0000_0000;
      if (i_avs_read && !ack) begin
        unique case (i_avs_address)
          // RQ19 go bit shows busy
          OFF_CTRL_ONE:
            o_avs_readdata[1:0] <= {state != ACS_IDLE, power_on};
          // RQ16 bits 3 and 2 read zero
          OFF_CTRL_TWO:
            o_avs_readdata[7:0] <= {format_right, clk_sel, 2'b00, ref_sel};
          OFF_AUX_TWO:  o_avs_readdata[2:0] <= trig_sel;
          OFF_IRQ_CTRL:
            o_avs_readdata[2:0] <= {gate, irq_en, done_flag};
          OFF_RES_HIGH: o_avs_readdata[7:0] <= res_high;
          OFF_RES_LOW:  o_avs_readdata[7:0] <= res_low;
          default:      ;
        endcase
      end
    end
  end

  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_start_rc;
    start_req && use_rc;
  endsequence
  sequence s_delay_run;
    (state == ACS_DELAY && !abort_req && !sleep_abort)[*4];
  endsequence

  property p_off_idle;
    !powered |=> state == ACS_IDLE;
  endproperty
  a_off_idle: assert property (p_off_idle) // RQ1
    else $error("conversion running while powered off");

  property p_start;
    start_req |=> state != ACS_IDLE;
  endproperty
  a_start: assert property (p_start) // RQ2
    else $error("start request did not begin a conversion");

  property p_finish;
    finish |=> state == ACS_IDLE && done_flag;
  endproperty
  a_finish: assert property (p_finish) // RQ4
    else $error("completion did not set done and clear busy");

  property p_abort;
    partial |=> state == ACS_IDLE && $stable(done_flag);
  endproperty
  a_abort: assert property (p_abort) // RQ5
    else $error("abort left converter busy");

  property p_rc_delay;
    s_start_rc ##1 s_delay_run |=> state == ACS_CONV;
  endproperty
  a_rc_delay: assert property (p_rc_delay) // RQ8
    else $error("RC start delay was not four cycles");

  property p_sleep_off;
    (finish && i_sleep && !irq_en) |=> sleep_off && power_on;
  endproperty
  a_sleep_off: assert property (p_sleep_off) // RQ10
    else $error("module not turned off after sleep completion");

  property p_sleep_abort;
    (state != ACS_IDLE && i_sleep && !use_rc) |=> state == ACS_IDLE;
  endproperty
  a_sleep_abort: assert property (p_sleep_abort) // RQ11
    else $error("sleep did not abort non-RC conversion");

  property p_trig_off;
    (state == ACS_IDLE && !powered) |=> state == ACS_IDLE;
  endproperty
  a_trig_off: assert property (p_trig_off) // RQ20
    else $error("conversion started while powered off");

  property p_irq;
    o_irq |-> $past(done_flag) && $past(irq_en) && $past(gate);
  endproperty
  a_irq: assert property (p_irq) // RQ18
    else $error("interrupt raised without enable and gate");

endmodule

/* dv/acs_analog_model.sv */
// Comparator model standing on the analog side of the sequencer.
`timescale 1ns/1ps
module acs_analog_model #(
  parameter int RES_W = 10
) (
  input  wire logic [RES_W-1:0] i_level,
  input  wire logic [RES_W-1:0] i_dac_code,
  output logic                  o_cmp
);
  // An analog comparator has no clock; it follows the trial code at once.
  assign o_cmp = (i_level >= i_dac_code);
endmodule

/* dv/test_acs_sequencer.sv */
// Self-checking testbench for the converter sequencer.
`timescale 1ns/1ps
module test_acs_sequencer;
  import acs_pkg::*;
  logic        clk, rst_n, rd, wr, rc, slp, cmp, smp, irq, wake, wreq;
  logic [4:0]  adr, trig;
  logic [31:0] wdata, rdata;
  logic [9:0]  lvl, dac;
  int          failures, check_count;

  // ------------------------------------------------------------
  // Clock and the slow RC tick
  // ------------------------------------------------------------
  // The clock toggles every half period of 5 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The RC tick runs free at one tenth of the system rate.
  initial begin
    rc = 1'b0;
    forever begin
      repeat (5) @(posedge clk);
      rc <= ~rc;
    end
  end

  acs_sequencer dut (
    .i_sys_clk        (clk),
    .i_reset_n        (rst_n),
    .i_avs_address    (adr),
    .i_avs_read       (rd),
    .i_avs_write      (wr),
    .i_avs_writedata  (wdata),
    .i_avs_byteenable (4'h1),
    .o_avs_readdata   (rdata),
    .o_avs_waitrequest(wreq),
    .i_cmp            (cmp),
    .i_rc_clk         (rc),
    .i_sleep          (slp),
    .i_trig           (trig),
    .o_dac_code       (dac),
    .o_sample         (smp),
    .o_irq            (irq),
    .o_wake           (wake)
  );
  acs_analog_model model (
    .i_level   (lvl),
    .i_dac_code(dac),
    .o_cmp     (cmp)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One Avalon access; the request holds until waitrequest is seen low.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    adr   <= a;
    wr    <= w;
    rd    <= ~w;
    wdata <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    chk("wait states", 16'h0002, 16'(n));
  endtask

  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [7:0] e,
                     input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, {8'h00, e}, {8'h00, q});
  endtask

  // Polls the busy bit; a hung conversion ends the poll after a bound.
  task automatic wait_idle();
    logic [7:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFF_CTRL_ONE, 8'h00, q);
      n++;
    end while (q[1] !== 1'b0 && n < 300);
    chk("busy clears", 16'h0000, {15'h0000, q[1]});
  endtask

  task automatic seen(input bit wk, input int lim, input string nm);
    logic hit;
    hit = 1'b0;
    for (int n = 0; n < lim && !hit; n++) begin
      @(posedge clk);
      hit = ((wk ? wake : smp) === 1'b1);
    end
    chk(nm, 16'h0001, {15'h0000, hit});
  endtask

  task automatic start();
    wrr(OFF_CTRL_ONE, 8'h01);
    wrr(OFF_CTRL_ONE, 8'h03);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rdc(OFF_CTRL_ONE, 8'h00, "ctrl one reset");
    rdc(OFF_CTRL_TWO, 8'h00, "ctrl two reset");
    rdc(5'h18, 8'h00, "unmapped");
    wrr(OFF_CTRL_TWO, 8'hFF);
    rdc(OFF_CTRL_TWO, 8'hF3, "ctrl two holes");
    wrr(5'h18, 8'hFF);
    rdc(5'h18, 8'h00, "unmapped write");
    $display("test regs done");
  endtask

  task automatic t_off();
    wrr(OFF_CTRL_TWO, 8'h00);
    wrr(OFF_CTRL_ONE, 8'h02);
    rdc(OFF_CTRL_ONE, 8'h00, "go while off");
    wrr(OFF_AUX_TWO, 8'h01);
    @(posedge clk) trig <= 5'h01;
    @(posedge clk) trig <= 5'h00;
    rdc(OFF_CTRL_ONE, 8'h00, "trigger while off");
    wrr(OFF_AUX_TWO, 8'h00);
    $display("test off done");
  endtask

  task automatic t_conv(input logic [7:0] c2, input logic [9:0] v,
                        input logic [7:0] hi, input logic [7:0] lo);
    lvl <= v;
    wrr(OFF_CTRL_TWO, c2);
    start();
    rdc(OFF_CTRL_ONE, 8'h03, "busy reads one");
    wait_idle();
    rdc(OFF_RES_HIGH, hi, "result high");
    rdc(OFF_RES_LOW, lo, "result low");
    rdc(OFF_IRQ_CTRL, 8'h01, "done flag");
    wrr(OFF_IRQ_CTRL, 8'h00);
    $display("test conversion done");
  endtask

  task automatic t_abort();
    lvl <= 10'h3FF;
    wrr(OFF_CTRL_TWO, 8'h90);
    start();
    repeat (40) @(posedge clk);
    wrr(OFF_CTRL_ONE, 8'h01);
    rdc(OFF_RES_HIGH, 8'h03, "partial high");
    rdc(OFF_RES_LOW, 8'hFF, "partial low");
    rdc(OFF_IRQ_CTRL, 8'h00, "no done on abort");
    $display("test abort done");
  endtask

  task automatic t_irq();
    wrr(OFF_IRQ_CTRL, 8'h03);
    repeat (2) @(posedge clk);
    chk("irq no gate", 16'h0000, {15'h0000, irq});
    wrr(OFF_IRQ_CTRL, 8'h07);
    repeat (2) @(posedge clk);
    chk("irq gated on", 16'h0001, {15'h0000, irq});
    wrr(OFF_IRQ_CTRL, 8'h05);
    repeat (2) @(posedge clk);
    chk("irq disabled", 16'h0000, {15'h0000, irq});
    wrr(OFF_IRQ_CTRL, 8'h00);
    $display("test irq done");
  endtask

  task automatic t_trig();
    lvl <= 10'h155; // input settled before triggers
    wrr(OFF_CTRL_TWO, 8'h80);
    for (int i = 0; i < 5; i++) begin
      wrr(OFF_AUX_TWO, 8'(i + 1));
      @(posedge clk) trig <= 5'(1 << i);
      @(posedge clk) trig <= 5'h00;
      wait_idle();
      rdc(OFF_IRQ_CTRL, 8'h01, "trigger done");
      rdc(OFF_RES_LOW, 8'h55, "trigger result");
      wrr(OFF_IRQ_CTRL, 8'h00);
    end
    wrr(OFF_AUX_TWO, 8'h00);
    $display("test trigger done");
  endtask

  task automatic t_rc();
    wrr(OFF_CTRL_TWO, 8'hB0);
    wrr(OFF_IRQ_CTRL, 8'h02);
    start();
    seen(1'b0, 20, "start delay");
    slp <= 1'b1;
    seen(1'b1, 600, "wake pulse");
    slp <= 1'b0;
    wait_idle();
    wrr(OFF_IRQ_CTRL, 8'h00);
    wrr(OFF_CTRL_ONE, 8'h03);
    slp <= 1'b1;
    wait_idle();
    rdc(OFF_CTRL_ONE, 8'h01, "power kept");
    wrr(OFF_CTRL_ONE, 8'h03);
    rdc(OFF_CTRL_ONE, 8'h01, "off in sleep");
    slp <= 1'b0;
    wrr(OFF_IRQ_CTRL, 8'h00);
    $display("test rc sleep done");
  endtask

  task automatic t_sleep_abort();
    wrr(OFF_CTRL_TWO, 8'h90);
    wrr(OFF_CTRL_ONE, 8'h03);
    repeat (20) @(posedge clk);
    slp <= 1'b1;
    repeat (5) @(posedge clk);
    rdc(OFF_CTRL_ONE, 8'h01, "sleep abort");
    rdc(OFF_IRQ_CTRL, 8'h00, "sleep no done");
    wrr(OFF_CTRL_ONE, 8'h03);
    rdc(OFF_CTRL_ONE, 8'h01, "off after abort");
    slp <= 1'b0;
    $display("test sleep abort done");
  endtask

  task automatic t_reset();
    wrr(OFF_CTRL_ONE, 8'h03);
    repeat (20) @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rdc(OFF_CTRL_ONE, 8'h00, "reset aborts");
    rdc(OFF_CTRL_TWO, 8'h00, "reset clears");
    $display("test reset done");
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  // Inputs get values at time zero; reset is held for three cycles.
  initial begin
    failures = 0;
    check_count = 0;
    rst_n = 1'b0;
    {rd, wr, slp} = 3'b000;
    adr = 5'h00;
    wdata = 32'h0000_0000;
    trig = 5'h00;
    lvl = 10'h000;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_off();
    t_conv(8'h80, 10'h2B5, 8'h02, 8'hB5);
    t_conv(8'h10, 10'h2B5, 8'hAD, 8'h40);
    t_conv(8'hC0, 10'h0C3, 8'h00, 8'hC3);
    t_conv(8'h20, 10'h1CA, 8'h72, 8'h80);
    t_abort();
    t_irq();
    t_trig();
    t_rc();
    t_sleep_abort();
    t_reset();
    final_report();
  end
  // A hang is cut off well past the expected run of about 1300 cycles.
  initial begin
    #500000;
    failures++;
    final_report();
  end
endmodule
